/* File: design/vta_monitor.sv */
// Valve travel alert monitor: alert checks, target shaping, cycle counting, shutdown.
// Assumes measurements, sample strobe and host writes all come from logic on i_mclk.
`timescale 1ns/100ps
`include "vta_params.svh"

module vta_monitor #(
    parameter int SAMPLE_HZ = `VTA_SAMPLE_HZ, // Sample strobes per second
    parameter int TMR_W = 32,                  // Deviation timer width
    parameter int CNT_W = 32                   // Cycle counter width
) (
    input logic i_mclk,                        // System clock
    input logic i_rst,                         // Synchronous reset, high
    input logic i_sample,                      // Sample strobe, one cycle
    input logic i_wr_en,                       // Config write strobe
    input vta_pkg::vta_wr_sel_e i_wr_sel,      // Config item selected
    input logic [15:0] i_wr_data,              // Config write value
    input logic [15:0] i_supply,               // Measured supply pressure
    input logic i_loop_fault,                  // Loop current out of range
    input vta_pkg::vta_pct_t i_setpoint,       // Pre-characterized set point
    input vta_pkg::vta_pct_t i_travel_ref,     // Characterized travel target
    input vta_pkg::vta_pct_t i_press_ref,      // Unshaped pressure target
    input vta_pkg::vta_pct_t i_travel,         // Ranged travel
    output vta_pkg::vta_alerts_s o_alerts,     // Alert flags
    output logic o_shutdown,                   // Zero-power shutdown latch
    output vta_pkg::vta_pct_t o_travel_target, // Shaped travel target
    output vta_pkg::vta_pct_t o_press_target,  // Shaped pressure target
    output logic [CNT_W-1:0] o_cycle_count,    // Cycle counter
    output vta_pkg::vta_cfg_s o_cfg            // Configuration readback
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    localparam vta_pkg::vta_cfg_s CFG_RST = '{
        sup_en: `VTA_DEF_SUP_EN, loop_en: `VTA_DEF_LOOP_EN, dev_en: `VTA_DEF_DEV_EN,
        hh_en: `VTA_DEF_LIM_EN, ll_en: `VTA_DEF_LIM_EN, hi_en: `VTA_DEF_LIM_EN,
        lo_en: `VTA_DEF_LIM_EN, cyc_en: `VTA_DEF_CYC_EN, sup_pt: `VTA_DEF_SUP_PT,
        dev_pt: `VTA_DEF_DEV_PT, dev_time: `VTA_DEF_DEV_TIME, hyst: `VTA_DEF_HYST,
        hh_pt: `VTA_DEF_HH_PT, ll_pt: `VTA_DEF_LL_PT, hi_pt: `VTA_DEF_HI_PT,
        lo_pt: `VTA_DEF_LO_PT, tcut_hi: `VTA_OFF_HI, tcut_lo: `VTA_OFF_LO,
        pcut_hi: `VTA_OFF_HI, pcut_lo: `VTA_OFF_LO, tlim_hi: `VTA_OFF_HI,
        tlim_lo: `VTA_OFF_LO, cyc_db: `VTA_DEF_CYC_DB, cyc_pt: `VTA_DEF_CYC_PT};

    // Widening to 18 bits keeps point plus or minus band from wrapping.
    function automatic logic signed [17:0] ext(input logic signed [15:0] v);
        return {{2{v[15]}}, v};
    endfunction

    // Hysteretic limit check: set past the point, clear a full band back.
    function automatic logic band_chk(input logic on, input logic en, input logic hi,
                                      input logic signed [15:0] v,
                                      input logic signed [15:0] pt,
                                      input logic signed [15:0] hy);
        if (!en) begin
            return 1'b0;
        end
        if (hi) begin
            return on ? (ext(v) > ext(pt) - ext(hy)) : (ext(v) > ext(pt));
        end
        return on ? (ext(v) < ext(pt) + ext(hy)) : (ext(v) < ext(pt));
    endfunction

    // ------------------------------------------------------------
    // Configuration store
    // ------------------------------------------------------------
    vta_pkg::vta_cfg_s cfg_q;
    vta_pkg::vta_cfg_s cfg_d;
    logic signed [15:0] wd;

    assign wd = $signed(i_wr_data);

    always_comb begin
        cfg_d = cfg_q;
        if (i_wr_en) begin
            unique case (i_wr_sel)
                vta_pkg::WR_SUP_EN: cfg_d.sup_en = i_wr_data[0];
                vta_pkg::WR_SUP_PT: cfg_d.sup_pt = i_wr_data;
                vta_pkg::WR_LOOP_EN: cfg_d.loop_en = i_wr_data[0];
                vta_pkg::WR_DEV_EN: cfg_d.dev_en = i_wr_data[0];
                vta_pkg::WR_DEV_PT: cfg_d.dev_pt = wd;
                vta_pkg::WR_DEV_TIME: cfg_d.dev_time = i_wr_data;
                vta_pkg::WR_HYST: cfg_d.hyst = wd;
                vta_pkg::WR_HH_EN: cfg_d.hh_en = i_wr_data[0];
                vta_pkg::WR_LL_EN: cfg_d.ll_en = i_wr_data[0];
                vta_pkg::WR_HI_EN: cfg_d.hi_en = i_wr_data[0];
                vta_pkg::WR_LO_EN: cfg_d.lo_en = i_wr_data[0];
                vta_pkg::WR_HH_PT: cfg_d.hh_pt = wd;
                vta_pkg::WR_LL_PT: cfg_d.ll_pt = wd;
                vta_pkg::WR_HI_PT: cfg_d.hi_pt = wd;
                vta_pkg::WR_LO_PT: cfg_d.lo_pt = wd;
                vta_pkg::WR_TCUT_HI, vta_pkg::WR_PCUT_HI: begin
                    if (i_wr_sel == vta_pkg::WR_TCUT_HI) begin
                        cfg_d.tcut_hi = wd;
                    end else begin
                        cfg_d.pcut_hi = wd;
                    end
                    cfg_d.tlim_hi = `VTA_OFF_HI;
                end
                vta_pkg::WR_TCUT_LO, vta_pkg::WR_PCUT_LO: begin
                    if (i_wr_sel == vta_pkg::WR_TCUT_LO) begin
                        cfg_d.tcut_lo = wd;
                    end else begin
                        cfg_d.pcut_lo = wd;
                    end
                    cfg_d.tlim_lo = `VTA_OFF_LO;
                end
                vta_pkg::WR_TLIM_HI: begin
                    cfg_d.tlim_hi = wd;
                    cfg_d.tcut_hi = `VTA_OFF_HI;
                    cfg_d.pcut_hi = `VTA_OFF_HI;
                end
                vta_pkg::WR_TLIM_LO: begin
                    cfg_d.tlim_lo = wd;
                    cfg_d.tcut_lo = `VTA_OFF_LO;
                    cfg_d.pcut_lo = `VTA_OFF_LO;
                end
                vta_pkg::WR_CYC_EN: cfg_d.cyc_en = i_wr_data[0];
                vta_pkg::WR_CYC_PT: cfg_d.cyc_pt = i_wr_data;
                vta_pkg::WR_CYC_DB: cfg_d.cyc_db = wd;
                vta_pkg::WR_CYC_CNT: cfg_d = cfg_q;
                default: cfg_d = cfg_q;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cfg_q <= CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Target shaping
    // ------------------------------------------------------------
    vta_pkg::vta_pct_t tt_q;
    vta_pkg::vta_pct_t tt_d;
    vta_pkg::vta_pct_t pt_q;
    vta_pkg::vta_pct_t pt_d;
    logic tcut_hi_hit;
    logic tcut_lo_hit;

    // A cutoff or limit parked at its sentinel is simply inactive.
    assign tcut_hi_hit = (cfg_q.tcut_hi != `VTA_OFF_HI) && (i_setpoint > cfg_q.tcut_hi);
    assign tcut_lo_hit = (cfg_q.tcut_lo != `VTA_OFF_LO) && (i_setpoint < cfg_q.tcut_lo);

    always_comb begin
        tt_d = tt_q;
        pt_d = pt_q;
        if (i_sample) begin
            tt_d = i_travel_ref;
            if (tcut_hi_hit) begin
                tt_d = `VTA_FORCE_HI;
            end else if (tcut_lo_hit) begin
                tt_d = `VTA_FORCE_LO;
            end else begin
                if (cfg_q.tlim_hi != `VTA_OFF_HI && i_travel_ref > cfg_q.tlim_hi) begin
                    tt_d = cfg_q.tlim_hi;
                end
                if (cfg_q.tlim_lo != `VTA_OFF_LO && i_travel_ref < cfg_q.tlim_lo) begin
                    tt_d = cfg_q.tlim_lo;
                end
            end
            pt_d = i_press_ref;
            if (cfg_q.pcut_hi != `VTA_OFF_HI && i_setpoint > cfg_q.pcut_hi) begin
                pt_d = `VTA_FORCE_HI;
            end else if (cfg_q.pcut_lo != `VTA_OFF_LO && i_setpoint < cfg_q.pcut_lo) begin
                pt_d = `VTA_FORCE_LO;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tt_q <= 16'sh0000;
            pt_q <= 16'sh0000;
        end else begin
            tt_q <= tt_d;
            pt_q <= pt_d;
        end
    end

    // ------------------------------------------------------------
    // Alerts, deviation timer, cycle counter, shutdown
    // ------------------------------------------------------------
    vta_pkg::vta_alerts_s al_q;
    vta_pkg::vta_alerts_s al_d;
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] tmr_d;
    logic [TMR_W-1:0] thr;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    vta_pkg::vta_pct_t ref_q;
    vta_pkg::vta_pct_t ref_d;
    vta_pkg::vta_dir_e dir_q;
    vta_pkg::vta_dir_e dir_d;
    logic sd_q;
    logic sd_d;
    logic signed [17:0] diff;
    logic signed [17:0] mag;
    logic dev_over;
    logic dev_clear;
    logic rev;
    logic cnt_wr;
    logic cyc_clr;

    assign thr = TMR_W'(cfg_q.dev_time) * TMR_W'(SAMPLE_HZ);
    assign diff = ext(tt_q) - ext(i_travel);
    assign mag = diff[17] ? -diff : diff;
    assign dev_over = mag > ext(cfg_q.dev_pt);
    assign dev_clear = mag < ext(cfg_q.dev_pt) - ext(cfg_q.hyst);
    assign cnt_wr = i_wr_en && (i_wr_sel == vta_pkg::WR_CYC_CNT);
    assign cyc_clr = cnt_wr && ({{(CNT_W-16){1'b0}}, i_wr_data} < CNT_W'(cfg_q.cyc_pt));

    always_comb begin
        al_d = al_q;
        tmr_d = tmr_q;
        ref_d = ref_q;
        dir_d = dir_q;
        rev = 1'b0;
        sd_d = sd_q | (i_sample & cfg_q.loop_en & i_loop_fault);
        if (i_sample) begin
            al_d.supply_lo = cfg_q.sup_en && (cfg_q.sup_pt != 16'h0000)
                             && (i_supply < cfg_q.sup_pt);
            al_d.travel_hh = band_chk(al_q.travel_hh, cfg_q.hh_en, 1'b1, i_travel,
                                      cfg_q.hh_pt, cfg_q.hyst);
            al_d.travel_ll = band_chk(al_q.travel_ll, cfg_q.ll_en, 1'b0, i_travel,
                                      cfg_q.ll_pt, cfg_q.hyst);
            al_d.travel_hi = band_chk(al_q.travel_hi, cfg_q.hi_en, 1'b1, i_travel,
                                      cfg_q.hi_pt, cfg_q.hyst);
            al_d.travel_lo = band_chk(al_q.travel_lo, cfg_q.lo_en, 1'b0, i_travel,
                                      cfg_q.lo_pt, cfg_q.hyst);
            if (!cfg_q.dev_en) begin
                tmr_d = '0;
                al_d.deviation = 1'b0;
            end else begin
                if (!dev_over) begin
                    tmr_d = '0;
                end else if (tmr_q != {TMR_W{1'b1}}) begin
                    tmr_d = tmr_q + TMR_W'(1);
                end
                if (!al_q.deviation && dev_over && tmr_d > thr) begin
                    al_d.deviation = 1'b1;
                end else if (al_q.deviation && dev_clear) begin
                    al_d.deviation = 1'b0;
                end
            end
            // Only reversals that leave the band around the reference are counted.
            unique case (dir_q)
                vta_pkg::DIR_NONE: begin
                    if (ext(i_travel) > ext(ref_q) + ext(cfg_q.cyc_db)) begin
                        dir_d = vta_pkg::DIR_UP;
                        ref_d = i_travel;
                    end else if (ext(i_travel) < ext(ref_q) - ext(cfg_q.cyc_db)) begin
                        dir_d = vta_pkg::DIR_DOWN;
                        ref_d = i_travel;
                    end
                end
                vta_pkg::DIR_UP: begin
                    if (i_travel > ref_q) begin
                        ref_d = i_travel;
                    end else if (ext(i_travel) < ext(ref_q) - ext(cfg_q.cyc_db)) begin
                        dir_d = vta_pkg::DIR_DOWN;
                        ref_d = i_travel;
                        rev = 1'b1;
                    end
                end
                vta_pkg::DIR_DOWN: begin
                    if (i_travel < ref_q) begin
                        ref_d = i_travel;
                    end else if (ext(i_travel) > ext(ref_q) + ext(cfg_q.cyc_db)) begin
                        dir_d = vta_pkg::DIR_UP;
                        ref_d = i_travel;
                        rev = 1'b1;
                    end
                end
                default: dir_d = vta_pkg::DIR_NONE;
            endcase
        end
        cnt_d = cnt_wr ? {{(CNT_W-16){1'b0}}, i_wr_data} : cnt_q;
        if (rev) begin
            cnt_d = cnt_d + CNT_W'(1);
        end
        // A new excess seen on a strobe outweighs a rewrite in the same cycle.
        al_d.cycle = cfg_q.cyc_en && ((al_q.cycle && !cyc_clr)
                     || (i_sample && cnt_q > CNT_W'(cfg_q.cyc_pt)));
    end

    // Shutdown is released only by reset, which stands in for a power cycle.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            al_q <= '0;
            tmr_q <= '0;
            cnt_q <= '0;
            ref_q <= 16'sh0000;
            dir_q <= vta_pkg::DIR_NONE;
            sd_q <= 1'b0;
        end else begin
            al_q <= al_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
            ref_q <= ref_d;
            dir_q <= dir_d;
            sd_q <= sd_d;
        end
    end

    assign o_alerts = al_q;
    assign o_shutdown = sd_q;
    assign o_travel_target = tt_q;
    assign o_press_target = pt_q;
    assign o_cycle_count = cnt_q;
    assign o_cfg = cfg_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_supply_lo;
        i_sample && cfg_q.sup_en && cfg_q.sup_pt != 16'h0000 && i_supply < cfg_q.sup_pt
        |=> o_alerts.supply_lo;
    endproperty
    a_supply_lo: assert property (p_supply_lo)
        else $error("Supply low alert missing.");

    property p_supply_zero;
        i_sample && cfg_q.sup_pt == 16'h0000 |=> !o_alerts.supply_lo;
    endproperty
    a_supply_zero: assert property (p_supply_zero)
        else $error("Supply alert raised with zero point.");

    property p_shutdown;
        i_sample && cfg_q.loop_en && i_loop_fault |=> o_shutdown [*8];
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("Shutdown not latched.");

    property p_dev_time;
        $rose(o_alerts.deviation) |-> tmr_q > thr && $past(i_sample);
    endproperty
    a_dev_time: assert property (p_dev_time)
        else $error("Deviation alert before its time.");

    property p_dev_hold;
        o_alerts.deviation && !(i_sample && dev_clear) && cfg_q.dev_en |=> o_alerts.deviation;
    endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("Deviation alert dropped early.");

    property p_dev_off;
        i_sample && !cfg_q.dev_en |=> !o_alerts.deviation && tmr_q == '0;
    endproperty
    a_dev_off: assert property (p_dev_off)
        else $error("Deviation check ran while disabled.");

    property p_hh_set;
        i_sample && cfg_q.hh_en && i_travel > cfg_q.hh_pt |=> o_alerts.travel_hh;
    endproperty
    a_hh_set: assert property (p_hh_set)
        else $error("High-high alert missing.");

    property p_lo_hold;
        i_sample && cfg_q.lo_en && o_alerts.travel_lo
        && ext(i_travel) < ext(cfg_q.lo_pt) + ext(cfg_q.hyst) |=> o_alerts.travel_lo;
    endproperty
    a_lo_hold: assert property (p_lo_hold)
        else $error("Low alert cleared inside band.");

    property p_cut_hi;
        i_sample && tcut_hi_hit |=> o_travel_target == `VTA_FORCE_HI;
    endproperty
    a_cut_hi: assert property (p_cut_hi)
        else $error("Travel high cutoff not applied.");

    property p_interlock;
        i_wr_en && i_wr_sel == vta_pkg::WR_TLIM_HI
        |=> cfg_q.tcut_hi == `VTA_OFF_HI && cfg_q.pcut_hi == `VTA_OFF_HI;
    endproperty
    a_interlock: assert property (p_interlock)
        else $error("High cutoff survived a limit write.");

    property p_cyc_alert;
        i_sample && cfg_q.cyc_en && cnt_q > CNT_W'(cfg_q.cyc_pt) |=> o_alerts.cycle;
    endproperty
    a_cyc_alert: assert property (p_cyc_alert)
        else $error("Cycle alert missing.");

    c_dev: cover property ($rose(o_alerts.deviation));
    c_shutdown: cover property ($rose(o_shutdown));
    c_cycle: cover property ($rose(o_alerts.cycle));
    c_cut: cover property (i_sample && tcut_lo_hit);

endmodule

/* File: shared/vta_params.svh */
// Constants of the valve travel alert monitor: defaults, sentinels and forced targets.
// Assumes percentages are signed 16-bit counts of 0.1 % of ranged travel or set point.
`ifndef VTA_PARAMS_SVH
`define VTA_PARAMS_SVH

// ------------------------------------------------------------
// Sentinels and forced targets
// ------------------------------------------------------------
`define VTA_OFF_HI 16'sh04e2
`define VTA_OFF_LO 16'shff06
`define VTA_FORCE_HI 16'sh04ce
`define VTA_FORCE_LO 16'shff1a

// ------------------------------------------------------------
// Factory defaults
// ------------------------------------------------------------
`define VTA_DEF_SUP_EN 1'b1
`define VTA_DEF_LOOP_EN 1'b0
`define VTA_DEF_DEV_EN 1'b1
`define VTA_DEF_LIM_EN 1'b0
`define VTA_DEF_CYC_EN 1'b0
`define VTA_DEF_SUP_PT 16'h0000
`define VTA_DEF_DEV_PT 16'sh0032
`define VTA_DEF_DEV_TIME 16'h000a
`define VTA_DEF_HYST 16'sh0014
`define VTA_DEF_HH_PT 16'sh041a
`define VTA_DEF_LL_PT 16'shffce
`define VTA_DEF_HI_PT 16'sh03b6
`define VTA_DEF_LO_PT 16'sh0032
`define VTA_DEF_CYC_DB 16'sh0064
`define VTA_DEF_CYC_PT 16'hffff

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define VTA_SAMPLE_HZ 100

`endif

/* File: shared/vta_pkg.sv */
// Types shared by the valve travel alert monitor and its bench.
// Assumes the constants header supplies every numeric value.
package vta_pkg;

    typedef logic signed [15:0] vta_pct_t;

    typedef enum logic [4:0] {
        WR_SUP_EN, WR_SUP_PT, WR_LOOP_EN, WR_DEV_EN, WR_DEV_PT, WR_DEV_TIME,
        WR_HYST, WR_HH_EN, WR_LL_EN, WR_HI_EN, WR_LO_EN, WR_HH_PT, WR_LL_PT,
        WR_HI_PT, WR_LO_PT, WR_TCUT_HI, WR_TCUT_LO, WR_PCUT_HI, WR_PCUT_LO,
        WR_TLIM_HI, WR_TLIM_LO, WR_CYC_EN, WR_CYC_PT, WR_CYC_DB, WR_CYC_CNT
    } vta_wr_sel_e;

    typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN} vta_dir_e;

    typedef struct packed {
        logic sup_en;
        logic loop_en;
        logic dev_en;
        logic hh_en;
        logic ll_en;
        logic hi_en;
        logic lo_en;
        logic cyc_en;
        logic [15:0] sup_pt;
        vta_pct_t dev_pt;
        logic [15:0] dev_time;
        vta_pct_t hyst;
        vta_pct_t hh_pt;
        vta_pct_t ll_pt;
        vta_pct_t hi_pt;
        vta_pct_t lo_pt;
        vta_pct_t tcut_hi;
        vta_pct_t tcut_lo;
        vta_pct_t pcut_hi;
        vta_pct_t pcut_lo;
        vta_pct_t tlim_hi;
        vta_pct_t tlim_lo;
        vta_pct_t cyc_db;
        logic [15:0] cyc_pt;
    } vta_cfg_s;

    typedef struct packed {
        logic supply_lo;
        logic deviation;
        logic travel_hh;
        logic travel_ll;
        logic travel_hi;
        logic travel_lo;
        logic cycle;
    } vta_alerts_s;

endpackage

/* File: tb/vta_monitor_tb_top.sv */
// Bench for the valve travel alert monitor.
// Assumes the sensor model drives strobe, supply and travel.
`timescale 1ns/100ps
module vta_monitor_tb_top;
    logic i_mclk, i_rst, go, wr_en, fault, smp, sd, ehh, ell, ehi, elo;
    vta_pkg::vta_wr_sel_e sel;
    logic [15:0] wd, sup, trv, s_sup, s_trv;
    vta_pkg::vta_pct_t sp, tref, pref, tt, pt, v;
    vta_pkg::vta_alerts_s al;
    vta_pkg::vta_cfg_s cfg;
    logic [31:0] cnt;
    int n_fail, cmp_count, seed, cyc, i;
    vta_pkg::vta_pct_t corner [12] = '{1051, 1031, 1030, 951, 931, 930,
        -51, -31, -30, 49, 69, 70};

    vta_sensor_model sm (.i_mclk(i_mclk), .i_go(go), .i_sup(sup), .i_trv(trv),
        .o_sample(smp), .o_sup(s_sup), .o_trv(s_trv));
    vta_monitor #(.SAMPLE_HZ(4)) uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sample(smp),
        .i_wr_en(wr_en), .i_wr_sel(sel), .i_wr_data(wd), .i_supply(s_sup),
        .i_loop_fault(fault), .i_setpoint(sp), .i_travel_ref(tref), .i_press_ref(pref),
        .i_travel(s_trv), .o_alerts(al), .o_shutdown(sd), .o_travel_target(tt),
        .o_press_target(pt), .o_cycle_count(cnt), .o_cfg(cfg));

    task automatic chk_b(string n, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic chk_v(string n, logic signed [31:0] e, logic signed [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %0d got %0d", n, e, g);
        end
    endtask
    task automatic wr(vta_pkg::vta_wr_sel_e s, logic [15:0] d);
        @(negedge i_mclk);
        wr_en = 1'b1;
        sel = s;
        wd = d;
        @(negedge i_mclk);
        wr_en = 1'b0;
    endtask
    task automatic strobe(logic [15:0] t);
        trv = t;
        @(negedge i_mclk);
        go = 1'b1;
        @(negedge i_mclk);
        go = 1'b0;
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic rst();
        @(negedge i_mclk);
        i_rst = 1'b1;
        repeat (5) @(negedge i_mclk);
        i_rst = 1'b0;
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hysteretic set/clear for an upper point; lower points pass negated values.
    function automatic logic hy(logic p, int x, int t);
        return x > t || (p && x > t - 20);
    endfunction

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        {i_rst, go, wr_en, fault, sup, trv, wd, sp, tref, pref} = '0;
        sel = vta_pkg::WR_SUP_EN;
        seed = 2591;
        i_rst = 1'b1;
        repeat (5) @(negedge i_mclk);
        i_rst = 1'b0;
        chk_b("sup_en", 1'b1, cfg.sup_en);
        chk_b("dev_en", 1'b1, cfg.dev_en);
        chk_b("lim_en", 1'b0, |{cfg.hh_en, cfg.ll_en, cfg.hi_en, cfg.lo_en});
        chk_b("cyc_en", 1'b0, cfg.cyc_en);
        strobe(16'h0000);
        chk_b("sup_lo", 1'b0, al.supply_lo);
        wr(vta_pkg::WR_SUP_PT, 16'h0100);
        sup = 16'($random(seed)) & 16'h00ff;
        strobe(16'h0000);
        chk_b("sup_lo", 1'b1, al.supply_lo);
        sup = 16'h0100;
        strobe(16'd1100);
        chk_b("sup_lo", 1'b0, al.supply_lo);
        chk_b("hh_off", 1'b0, al.travel_hh);
        for (i = 0; i < 4; i++) wr(vta_pkg::vta_wr_sel_e'(7 + i), 16'h0001);
        {ehh, ell, ehi, elo} = '0;
        for (i = 0; i < 42; i++) begin
            v = (i < 12) ? corner[i] : 16'($random(seed) % 800 + 500);
            strobe(v);
            ehh = hy(ehh, v, 1050);
            ell = hy(ell, -v, 50);
            ehi = hy(ehi, v, 950);
            elo = hy(elo, -v, -50);
            chk_b("hh", ehh, al.travel_hh);
            chk_b("ll", ell, al.travel_ll);
            chk_b("hi", ehi, al.travel_hi);
            chk_b("lo", elo, al.travel_lo);
        end
        // A wider band must widen the clear margin of the high-high and low-low travel alerts.
        wr(vta_pkg::WR_HYST, 16'h0028);
        strobe(16'd1051);
        strobe(16'd1020);
        chk_b("hh_hyst", 1'b1, al.travel_hh);
        strobe(-16'sd51);
        strobe(-16'sd20);
        chk_b("ll_hyst", 1'b1, al.travel_ll);
        rst();
        wr(vta_pkg::WR_DEV_TIME, 16'h0001);
        tref = 16'sd500;
        strobe(16'h0000);
        for (i = 1; i <= 5; i++) begin
            strobe(16'h0000);
            chk_b("dev", i == 5, al.deviation);
        end
        strobe(16'd470);
        chk_b("dev", 1'b1, al.deviation);
        strobe(16'd480);
        chk_b("dev", 1'b0, al.deviation);
        wr(vta_pkg::WR_DEV_EN, 16'h0000);
        for (i = 0; i < 6; i++) strobe(16'h0000);
        chk_b("dev_off", 1'b0, al.deviation);
        wr(vta_pkg::WR_DEV_EN, 16'h0001);
        for (i = 0; i < 5; i++) strobe(16'h0000);
        chk_b("dev_on", 1'b1, al.deviation);
        rst();
        wr(vta_pkg::WR_TCUT_HI, 16'd995);
        wr(vta_pkg::WR_PCUT_HI, 16'd995);
        sp = 16'sd1000;
        strobe(16'h0000);
        chk_v("tt", 1230, tt);
        chk_v("pt", 1230, pt);
        wr(vta_pkg::WR_TCUT_LO, 16'd5);
        wr(vta_pkg::WR_PCUT_LO, 16'd5);
        sp = 16'sd0;
        strobe(16'h0000);
        chk_v("tt", -230, tt);
        chk_v("pt", -230, pt);
        wr(vta_pkg::WR_TLIM_HI, 16'd900);
        wr(vta_pkg::WR_TLIM_LO, 16'd100);
        chk_v("tcut_hi", 1250, cfg.tcut_hi);
        chk_v("pcut_lo", -250, cfg.pcut_lo);
        sp = 16'sd500;
        tref = 16'sd1000;
        pref = 16'($random(seed) % 1000);
        strobe(16'h0000);
        chk_v("tt", 900, tt);
        chk_v("pt", pref, pt);
        tref = -16'sd100;
        strobe(16'h0000);
        chk_v("tt", 100, tt);
        wr(vta_pkg::WR_TCUT_HI, 16'd995);
        chk_v("tlim_hi", 1250, cfg.tlim_hi);
        rst();
        wr(vta_pkg::WR_CYC_EN, 16'h0001);
        wr(vta_pkg::WR_CYC_PT, 16'h0001);
        strobe(16'd0);
        strobe(16'd200);
        strobe(16'd50);
        chk_v("cnt", 1, cnt);
        strobe(16'd250);
        strobe(16'd250);
        chk_v("cnt", 2, cnt);
        chk_b("cyc", 1'b1, al.cycle);
        wr(vta_pkg::WR_CYC_CNT, 16'h0005);
        chk_v("cnt", 5, cnt);
        chk_b("cyc_keep", 1'b1, al.cycle);
        wr(vta_pkg::WR_CYC_CNT, 16'h0000);
        chk_v("cnt", 0, cnt);
        chk_b("cyc", 1'b0, al.cycle);
        fault = 1'b1;
        strobe(16'd0);
        chk_b("sd", 1'b0, sd);
        wr(vta_pkg::WR_LOOP_EN, 16'h0001);
        strobe(16'd0);
        fault = 1'b0;
        strobe(16'd0);
        chk_b("sd", 1'b1, sd);
        rst();
        chk_b("sd", 1'b0, sd);
        wrap_up();
    end
endmodule

/* File: tb/vta_sensor_model.sv */
// Sensor path model: makes the sample strobe and presents supply and travel.
// Assumes requests arrive at the falling edge of i_mclk.
`timescale 1ns/100ps
module vta_sensor_model (
    input wire logic i_mclk, // Clock
    input wire logic i_go, // Strobe request
    input wire logic [15:0] i_sup, // Supply value
    input wire logic [15:0] i_trv, // Travel value
    output logic o_sample, // Sample strobe
    output logic [15:0] o_sup, // Supply to block
    output logic [15:0] o_trv // Travel to block
);
    initial o_sample = 1'b0;
    // Off the strobe the values are inverted, so stale samples cannot pass.
    always @(posedge i_mclk) begin
        o_sample <= i_go;
        o_sup <= i_go ? i_sup : ~i_sup;
        o_trv <= i_go ? i_trv : ~i_trv;
    end
endmodule
